// ### tb.sv
/*
  self-checking bench of the comb filter with a converter model.
  assumes the divider base is shortened to 4 cycles.
*/
`timescale 1ns/100ps
module tb;
  logic               clk_in;
  logic               sys_rst_in;
  logic               restart;
  logic [2:0]         code;
  logic               tick;
  logic               valid;
  logic [2:0]         act;
  vcf_pkg::vcf_axes_s early;
  vcf_pkg::vcf_axes_s late;
  vcf_pkg::vcf_axes_s adc;
  vcf_pkg::vcf_axes_s res;
  int                 errors;
  int                 comparisons;
  int                 ticks = 0;
  vcf_comb_filter #(.BASE_DIV(4)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .filter_clock_control_in(code),
    .adc_in(adc), .sample_tick_out(tick), .result_out(res),
    .result_valid_out(valid), .active_setting_out(act));
  vcf_adc_model u_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .restart_in(restart),
    .sample_tick_in(tick), .early_in(early), .late_in(late), .adc_out(adc));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  task check(input string name, input logic [27:0] seen, input logic [27:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task set_code(input logic [2:0] c);
    @(posedge clk_in);
    code <= c;
    restart <= 1'b1;
    @(posedge clk_in);
    restart <= 1'b0;
    #1;
  endtask
  task wait_tick(output int gap);
    gap = 0;
    do begin step(1); gap++; end while (tick !== 1'b1 && gap < 1000);
  endtask
  task wait_valid(input int lim);
    int n;
    for (n = 0; n < lim && valid !== 1'b1; n++) step(1);
    check("valid", valid, 28'h1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_rates;
    int g;
    for (int c = 0; c < 8; c++) begin
      set_code(3'(c));
      check("setting", act, (c > 5) ? 28'h5 : 28'(c));
      wait_tick(g);
      wait_tick(g);
      check("tick gap", 28'(g), (c > 5) ? 28'd128 : 28'(4 << c));
    end
  endtask
  task t_result;
    int t0;
    early = 28'h1555_2AA;
    late  = 28'h3F00_123;
    set_code(3'h0);
    t0 = ticks;
    wait_valid(9000);
    check("ticks per word", 28'(ticks - t0), 28'd2048);
    check("result", res, 28'h3F00_123);
    @(posedge clk_in);
    late <= 28'h0ABC_FFF;
    step(1);
    check("valid pulse", valid, 28'h0);
    check("held", res, 28'h3F00_123);
    wait_valid(9000);
    check("result", res, 28'h0ABC_FFF);
  endtask
  task t_change;
    int seen;
    int t0;
    seen = 0;
    set_code(3'h1);
    t0 = ticks;
    // stop deep inside the weighted part so the accumulators hold partial sums
    for (int i = 0; i < 13000 && ticks - t0 < 1500; i++) step(1);
    check("ticks at 50k", 28'(ticks - t0), 28'd1500);
    late <= 28'h2001_1FF;
    set_code(3'h0);
    for (int i = 0; i < 8100; i++) begin
      step(1);
      if (valid === 1'b1) seen++;
    end
    check("early words", 28'(seen), 28'h0);
    check("held", res, 28'h0ABC_FFF);
    wait_valid(400);
    check("result", res, 28'h2001_1FF);
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    results;
  end
  initial begin
    sys_rst_in = 1'b1;
    code = 3'h0;
    restart = 1'b0;
    early = '0;
    late = '0;
    errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    step(1);
    check("reset setting", act, 28'h0);
    check("reset result", res, 28'h0);
    check("reset valid", valid, 28'h0);
    t_rates;
    t_result;
    t_change;
    results;
  end
endmodule

// ### vcf_adc_model.sv
/*
  converter model feeding both axes to the comb filter.
  assumes sample_tick_in is the filter's one-cycle sample strobe.
*/
`timescale 1ns/100ps
module vcf_adc_model (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               restart_in,
  input  wire logic               sample_tick_in,
  input  wire vcf_pkg::vcf_axes_s early_in,
  input  wire vcf_pkg::vcf_axes_s late_in,
  output vcf_pkg::vcf_axes_s      adc_out
);
  logic [10:0]        phase_q;
  vcf_pkg::vcf_axes_s cur;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || restart_in) begin
      phase_q <= 11'h000;
    end else if (sample_tick_in) begin
      phase_q <= phase_q + 11'h001;
    end
  end
  // the early part of a period must not reach the result
  assign cur = (phase_q < 11'h401) ? early_in : late_in;
  // off the strobe the lines show garbage, not the last sample
  assign adc_out = sample_tick_in ? cur : ~cur;
endmodule

// ### vcf_comb_filter.sv
/*
  two-axis decimating anti-vibration comb filter with six sample rates.
  assumes converter samples are synchronous to clk_in and valid whenever
  sample_tick_out is high; the rate setting is a plain level input.
*/
// Behaviour
// - each axis passes through two cascaded moving-sum stages before output.
// - each comb stage spans 512 samples; result is squared normalized sum.
// - host sets configuration; host picks rejection versus output rate trade-off.
// - exactly six sample rates: 100, 50, 25, 12.5, 6.25, 3.125 kHz.
// - one output word per 2048 samples: 48.8 Hz down to 1.5 Hz.
// - clock choice and output rate come from the filter clock control.
`timescale 1ns/100ps

module vcf_comb_filter #(
  parameter int BASE_DIV = vcf_pkg::BASE_DIV
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [2:0]        filter_clock_control_in,
  input  wire vcf_pkg::vcf_axes_s adc_in,
  output logic                   sample_tick_out,
  output vcf_pkg::vcf_axes_s     result_out,
  output logic                   result_valid_out,
  output logic [2:0]             active_setting_out
);

  vcf_pkg::vcf_top_state_s s_q;
  vcf_pkg::vcf_top_state_s s_d;

  logic                            code_ok;
  logic                            chg;
  logic [vcf_pkg::DIV_W-1:0]       div_lim;
  logic [vcf_pkg::PHASE_W-1:0]     widx;
  logic [vcf_pkg::WEIGHT_W-1:0]    weight;
  logic                            take;
  logic                            dump;
  logic                            done_x;
  logic                            done_y;
  // each axis drives its own half; the struct is assembled in one place
  logic signed [vcf_pkg::SAMPLE_W-1:0] res_x;
  logic signed [vcf_pkg::SAMPLE_W-1:0] res_y;

  // ----------------------------------------------------------------
  // rate selection
  // ----------------------------------------------------------------
  // codes 6 and 7 are ignored so the filter never runs at an undefined rate
  assign code_ok = filter_clock_control_in <= vcf_pkg::RATE_3K125;
  assign chg     = code_ok && (filter_clock_control_in != s_q.rate);
  assign div_lim = vcf_pkg::DIV_W'(32'(BASE_DIV) << s_q.rate);

  // ----------------------------------------------------------------
  // window weight
  // ----------------------------------------------------------------
  always_comb begin
    widx   = vcf_pkg::PHASE_W'(s_q.phase - vcf_pkg::WIN_START);
    weight = '0;
    if (s_q.phase >= vcf_pkg::WIN_START) begin
      if (widx < vcf_pkg::COMB_LEN_P) begin
        weight = vcf_pkg::WEIGHT_W'(widx + 11'h001);
      end else begin
        weight = vcf_pkg::WEIGHT_W'(vcf_pkg::WIN_LAST_J + 11'h001 - widx);
      end
    end
  end

  assign take = s_q.tick && !chg;
  assign dump = s_q.phase == vcf_pkg::PHASE_LAST;

  // ----------------------------------------------------------------
  // sample clock divider and decimation counter
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'h0;
    s_d.gap  = vcf_pkg::DIV_W'(s_q.gap + 16'h0001);
    if (chg) begin
      // restart timing so the first new result covers a full period
      s_d.rate    = vcf_pkg::vcf_rate_e'(filter_clock_control_in);
      s_d.div_cnt = '0;
      s_d.phase   = '0;
      s_d.gap     = '0;
    end else begin
      if (s_q.div_cnt == div_lim - 16'h0001) begin
        s_d.div_cnt = '0;
        s_d.tick    = 1'h1;
      end else begin
        s_d.div_cnt = vcf_pkg::DIV_W'(s_q.div_cnt + 16'h0001);
      end
      if (s_q.tick) begin
        s_d.phase = vcf_pkg::PHASE_W'(s_q.phase + 11'h001);
        s_d.gap   = '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q      <= '0;
      s_q.rate <= vcf_pkg::RATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // per-axis comb filters
  // ----------------------------------------------------------------
  vcf_tri_acc u_acc_x (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .clear_in        (chg),
    .sample_valid_in (take),
    .sample_in       (adc_in.x),
    .weight_in       (weight),
    .dump_in         (dump),
    .result_out      (res_x),
    .done_out        (done_x)
  );

  vcf_tri_acc u_acc_y (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .clear_in        (chg),
    .sample_valid_in (take),
    .sample_in       (adc_in.y),
    .weight_in       (weight),
    .dump_in         (dump),
    .result_out      (res_y),
    .done_out        (done_y)
  );

  assign result_out         = {res_x, res_y};
  assign sample_tick_out    = s_q.tick;
  assign result_valid_out   = done_x;
  assign active_setting_out = s_q.rate;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence last_sample_taken;
    s_q.tick && !chg && s_q.phase == vcf_pkg::PHASE_LAST;
  endsequence

  chk_result_after_window: assert property (
    result_valid_out |-> $past(s_q.tick && s_q.phase == vcf_pkg::PHASE_LAST)
    && done_y
  ) else $error("result valid without a completed window");

  chk_weight_peak_512: assert property (
    (s_q.phase == 11'h600) |-> weight == vcf_pkg::WEIGHT_PEAK
  ) else $error("window weight peak is not 512");

  chk_setting_taken: assert property (
    chg |=> active_setting_out == $past(filter_clock_control_in)
  ) else $error("new filter setting not taken");

  chk_six_rates_only: assert property (
    active_setting_out <= 3'h5 && div_lim >= 16'(BASE_DIV)
  ) else $error("filter rate outside the six settings");

  chk_tick_spacing: assert property (
    s_q.tick |-> s_q.gap >= div_lim - 16'h0001 && s_q.gap <= div_lim
  ) else $error("sample tick spacing differs from selected rate");

  chk_result_once_per_frame: assert property (
    last_sample_taken |=> result_valid_out ##1 !result_valid_out
  ) else $error("output word not produced once per 2048 samples");

  chk_bad_code_ignored: assert property (
    !code_ok |=> $stable(active_setting_out)
  ) else $error("invalid filter clock code changed the rate");

  chk_change_clears: assert property (
    chg |=> s_q.phase == '0 && s_q.div_cnt == '0 && $stable(result_out)
    && !result_valid_out
  ) else $error("rate change did not clear or did not hold output");

  sequence window_opens;
    s_q.phase == vcf_pkg::WIN_START;
  endsequence

  sequence window_closes;
    s_q.phase == vcf_pkg::PHASE_LAST;
  endsequence

  chk_axes_in_step: assert property (
    done_x == done_y
  ) else $error("axis results out of step");

  chk_early_weight_zero: assert property (
    (s_q.phase < vcf_pkg::WIN_START) |-> weight == '0
  ) else $error("sample before the window carries weight");

  chk_window_open_weight: assert property (
    window_opens |-> weight == 10'h001
  ) else $error("window does not start at weight one");

  chk_window_close_weight: assert property (
    window_closes |-> weight == 10'h001
  ) else $error("window does not end at weight one");

  chk_phase_advances: assert property (
    take |=> s_q.phase == vcf_pkg::PHASE_W'($past(s_q.phase) + 11'h001)
  ) else $error("decimation phase did not advance on a sample");

  chk_tick_one_cycle: assert property (
    s_q.tick |=> !s_q.tick
  ) else $error("sample tick longer than one cycle");

  chk_setting_holds: assert property (
    !chg |=> $stable(active_setting_out)
  ) else $error("filter setting changed without a valid new code");

  chk_hold_between_words: assert property (
    !result_valid_out |-> $stable(result_out)
  ) else $error("output changed without a new result");

endmodule

// ### vcf_pkg.sv
/*
  shared constants and types of the vibration comb filter: comb geometry,
  decimation, sample clock timing, rate codes and state records.
  assumes a 125 MHz system clock and 14-bit two's complement samples.
*/
package vcf_pkg;

  // ----------------------------------------------------------------
  // filter geometry
  // ----------------------------------------------------------------
  localparam int COMB_LEN    = 512;
  localparam int DECIM_RATIO = 2048;
  localparam int WIN_LEN     = 2 * COMB_LEN - 1;
  localparam int NORM_SHIFT  = 18;
  localparam int SAMPLE_W    = 14;
  localparam int ACC_W       = 34;
  localparam int WEIGHT_W    = 10;
  localparam int PHASE_W     = 11;

  localparam logic [PHASE_W-1:0]  WIN_START  = 11'h401;
  localparam logic [PHASE_W-1:0]  PHASE_LAST = 11'h7FF;
  localparam logic [PHASE_W-1:0]  COMB_LEN_P = 11'h200;
  localparam logic [PHASE_W-1:0]  WIN_LAST_J = 11'h3FE;
  localparam logic [WEIGHT_W-1:0] WEIGHT_PEAK = 10'h200;

  // ----------------------------------------------------------------
  // sample clock timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int BASE_PERIOD_NS = 10000;
  localparam int BASE_DIV       = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W          = 16;

  // ----------------------------------------------------------------
  // sample rate settings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_100K  = 3'b000,
    RATE_50K   = 3'b001,
    RATE_25K   = 3'b010,
    RATE_12K5  = 3'b011,
    RATE_6K25  = 3'b100,
    RATE_3K125 = 3'b101
  } vcf_rate_e;

  localparam vcf_rate_e RATE_RESET = RATE_100K;

  // ----------------------------------------------------------------
  // carriers and state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
  } vcf_axes_s;

  typedef struct packed {
    logic signed [ACC_W-1:0]    acc;
    logic signed [SAMPLE_W-1:0] result;
    logic                       done;
  } vcf_acc_state_s;

  typedef struct packed {
    logic [DIV_W-1:0]   div_cnt;
    logic [PHASE_W-1:0] phase;
    vcf_rate_e          rate;
    logic               tick;
    logic [DIV_W-1:0]   gap;
  } vcf_top_state_s;

endpackage

// ### vcf_tri_acc.sv
/*
  one axis of the comb filter: weighted accumulate-and-dump.
  assumes the caller supplies the window weight per sample and marks
  the last sample of each decimation period with dump_in.
*/
`timescale 1ns/100ps

module vcf_tri_acc #(
  parameter int ACC_W    = vcf_pkg::ACC_W,
  parameter int SAMPLE_W = vcf_pkg::SAMPLE_W,
  parameter int WEIGHT_W = vcf_pkg::WEIGHT_W
) (
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       clear_in,
  input  wire logic                       sample_valid_in,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic [WEIGHT_W-1:0]        weight_in,
  input  wire logic                       dump_in,
  output logic signed [SAMPLE_W-1:0]      result_out,
  output logic                            done_out
);

  vcf_pkg::vcf_acc_state_s s_q;
  vcf_pkg::vcf_acc_state_s s_d;
  logic signed [ACC_W-1:0] prod;
  logic signed [ACC_W-1:0] sum;

  // two cascaded length-512 moving sums sampled once per period equal a
  // triangular weighting of the last 1023 samples; no sample memory needed
  always_comb begin
    prod   = ACC_W'(sample_in) * ACC_W'($signed({1'h0, weight_in}));
    sum    = s_q.acc + prod;
    s_d    = s_q;
    s_d.done = 1'h0;
    if (clear_in) begin
      s_d.acc = '0;
    end else if (sample_valid_in) begin
      if (dump_in) begin
        // divide by 512 squared: the squared normalized sum
        s_d.result = SAMPLE_W'(sum >>> vcf_pkg::NORM_SHIFT);
        s_d.acc    = '0;
        s_d.done   = 1'h1;
      end else begin
        s_d.acc = sum;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result_out = s_q.result;
  assign done_out   = s_q.done;

endmodule
